// ===== include/intc_pkg.sv
// Constants, register map and types of the prioritized interrupt controller.
// Assumes a single clock domain and a plain byte-wide register port.
// What this block does
// RULE1: Two-bit priority field per system, levels 0-3.
// RULE2: Equal levels resolved by fixed vector order.
// RULE3: Reset clears every priority field to zero.
// RULE4: Accept only levels above the CPU mask.
// RULE5: Watchdog NMI is level 4, always accepted.
// RULE6: Maskable acceptance loads mask with accepted level.
// RULE7: NMI acceptance sets both mask bits.
// RULE8: Return restores previous mask, four nesting levels.
// RULE9: Current instruction completes before exception entry.
// RULE10: Push PC and flags; maximum mode adds bank.
// RULE11: Two-byte vector fetched into PC, no bank.
// RULE12: Vectors in steps of two, descending priority.
// RULE13: Vector 26h reserved; 28h-FEh software interrupts.
// RULE14: Enable bits gate requests, readable, reset zero.
// RULE15: Enable bits map onto flags bit for bit.
// RULE16: Priority fields located at fixed register bits.
// RULE17: Order within a system fixed in hardware.
// RULE18: Flags set on event, write one clears.
// RULE19: Request needs flag, enable and level above mask.
// RULE20: Unimplemented bits read zero, ignore writes.
// RULE21: Highest passing level presented, vector order ties.
package intc_pkg;
   localparam logic [23:0] PRIO_A_ADDR = 24'h00FF20;
   localparam logic [23:0] PRIO_B_ADDR = 24'h00FF21;
   localparam logic [23:0] TIMER_EN_ADDR = 24'h00FF22;
   localparam logic [23:0] IO_EN_ADDR = 24'h00FF23;
   localparam logic [23:0] TIMER_FLAG_ADDR = 24'h00FF24;
   localparam logic [23:0] IO_FLAG_ADDR = 24'h00FF25;
   localparam logic [23:0] CONV_PRIO_ADDR = 24'h00FF28;
   localparam logic [23:0] CONV_EN_ADDR = 24'h00FF2A;
   localparam logic [23:0] CONV_FLAG_ADDR = 24'h00FF2C;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] PRIO_B_MASK = 8'h0F;
   localparam logic [7:0] TIMER_MASK = 8'h7F;
   localparam logic [7:0] CONV_PRIO_MASK = 8'hC0;
   localparam logic [7:0] CONV_EN_MASK = 8'h80;
   localparam int NUM_SRC = 16;
   localparam int NMI_INDEX = 16;
   localparam logic [2:0] NMI_LEVEL = 3'h4;
   localparam logic [1:0] MASK_RESET = 2'h0;
   localparam logic [1:0] MASK_AFTER_NMI = 2'h3;
   localparam int NEST_DEPTH = 4;
   localparam logic [23:0] VEC_RESET = 24'h000000;
   localparam logic [23:0] VEC_NMI = 24'h000004;
   localparam logic [23:0] VEC_FIRST_SRC = 24'h000006;
   localparam logic [23:0] VEC_LAST_SRC = 24'h000024;
   localparam logic [23:0] VEC_RESERVED = 24'h000026;
   localparam logic [23:0] VEC_SOFT_LO = 24'h000028;
   localparam logic [23:0] VEC_SOFT_HI = 24'h0000FE;
   localparam logic [23:0] VEC_STEP = 24'h000002;
   typedef enum logic [2:0] {
      SYS_PTIMER, SYS_KEY1, SYS_KEY0, SYS_SERIAL, SYS_SWATCH, SYS_CTIMER, SYS_CONV
   } system_t;
   typedef enum {IDLE, WAIT_INSN, PUSH_PC_LO, PUSH_PC_HI, PUSH_FLAGS, PUSH_BANK,
      FETCH_LO, FETCH_HI, DONE} seq_t;
endpackage : intc_pkg

// ===== include/nest_if.sv
// Interface between the controller and its mask nesting store.
// Assumes both ends share mclk.
`timescale 1ns/1ps
`default_nettype none
interface nest_if;
   logic push;
   logic pop;
   logic [1:0] pushData;
   logic [1:0] popData;
   logic empty;
   modport ctrl (output push, output pop, output pushData, input popData, input empty);
   modport store (input push, input pop, input pushData, output popData, output empty);
endinterface : nest_if
`default_nettype wire

// ===== src/mask_stack.sv
// Small stack that keeps the CPU mask held before each accepted interrupt.
// Assumes push and pop never occur together; read data come from a register.
`timescale 1ns/1ps
`default_nettype none
module mask_stack
   import intc_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   nest_if.store nest
);
   logic [1:0] mem [NEST_DEPTH];
   logic [2:0] depth;
   logic [1:0] topData;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         depth <= 3'h0;
      end else if (nest.push && depth != 3'(NEST_DEPTH)) begin
         depth <= depth + 3'h1;
      end else if (nest.pop && depth != 3'h0) begin
         depth <= depth - 3'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (nest.push && depth != 3'(NEST_DEPTH)) begin
         mem[depth[1:0]] <= nest.pushData;
      end
   end

   // The top entry is registered so a pop sees its value without a memory read path.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         topData <= 2'h0;
      end else if (nest.push && depth != 3'(NEST_DEPTH)) begin
         topData <= nest.pushData;
      end else if (nest.pop && depth > 3'h1) begin
         topData <= mem[2'(depth - 3'h2)];
      end
   end

   assign nest.popData = topData;
   assign nest.empty = (depth == 3'h0);
endmodule : mask_stack
`default_nettype wire

// ===== src/prioritized_interrupt_controller.sv
// Interrupt controller: flags, enables, priorities, mask handling and exception entry.
// Assumes the CPU pulses instrDone at each instruction end and retire on return.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module prioritized_interrupt_controller
   import intc_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [23:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdata,
   input wire logic [NUM_SRC-1:0] srcEvent,
   input wire logic nmiEvent,
   input wire logic instrDone,
   input wire logic retire,
   input wire logic maxMode,
   input wire logic [15:0] pcIn,
   input wire logic [7:0] flagsIn,
   input wire logic [7:0] bankIn,
   input wire logic [15:0] vectorData,
   output logic [1:0] cpuMask,
   output logic requestPending,
   output logic [2:0] requestLevel,
   output logic [23:0] vectorAddr,
   output logic stackWrite,
   output logic [7:0] stackData,
   output logic vectorRead,
   output logic pcLoad,
   output logic [15:0] pcOut,
   output logic entryBusy
);
   // Source index i has vector VEC_FIRST_SRC + 2*i; index 15 is the converter.
   logic [7:0] prioA, prioB, timerEn, ioEn, timerFlag, ioFlag, convPrio, convEn, convFlag;
   logic [NUM_SRC-1:0] flagVec, enVec;
   logic nmiFlag;
   seq_t state;
   logic [4:0] takenIdx;
   logic [15:0] pcHold;
   logic [7:0] flagsHold;
   logic [7:0] vecLow;
   logic [2:0] bestLevel;
   logic [4:0] bestIdx;
   logic bestValid;
   nest_if nest ();

   function automatic system_t systemOf(input logic [4:0] idx);
      if (idx < 5'h02) return SYS_PTIMER;
      else if (idx == 5'h02) return SYS_KEY1;
      else if (idx < 5'h05) return SYS_KEY0;
      else if (idx < 5'h08) return SYS_SERIAL;
      else if (idx < 5'h0B) return SYS_SWATCH;
      else if (idx < 5'h0F) return SYS_CTIMER;
      else return SYS_CONV;
   endfunction : systemOf

   function automatic logic [1:0] levelOf(input system_t s, input logic [7:0] a,
         input logic [7:0] b, input logic [7:0] c);
      case (s)
         SYS_CTIMER: return a[1:0]; // RULE16
         SYS_SWATCH: return a[3:2];
         SYS_SERIAL: return a[5:4];
         SYS_KEY0: return a[7:6];
         SYS_KEY1: return b[1:0];
         SYS_PTIMER: return b[3:2];
         SYS_CONV: return c[7:6];
         default: return 2'h0;
      endcase
   endfunction : levelOf

   function automatic logic hit(input logic [23:0] a, input logic [23:0] r);
      return a == r;
   endfunction : hit

   // Flags laid out in vector order; registers keep their own bit positions.
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_io
         assign flagVec[gi] = ioFlag[7-gi]; // RULE15
         assign enVec[gi] = ioEn[7-gi];
      end
      for (gi = 0; gi < 7; gi++) begin : g_tm
         assign flagVec[8+gi] = timerFlag[6-gi];
         assign enVec[8+gi] = timerEn[6-gi];
      end
   endgenerate
   assign flagVec[15] = convFlag[7];
   assign enVec[15] = convEn[7];

   // Highest level wins; strict compare keeps the lowest vector on ties.
   always_comb begin
      logic [2:0] lvl;
      lvl = 3'h0;
      bestLevel = 3'h0;
      bestIdx = 5'h0;
      bestValid = 1'b0;
      if (nmiFlag) begin
         bestLevel = NMI_LEVEL; // RULE5
         bestIdx = 5'(NMI_INDEX);
         bestValid = 1'b1;
      end
      for (int i = 0; i < NUM_SRC; i++) begin
         lvl = {1'b0, levelOf(systemOf(5'(i)), prioA, prioB, convPrio)}; // RULE1 RULE17
         if (flagVec[i] && enVec[i] && lvl > {1'b0, cpuMask} && lvl > bestLevel) begin
            bestLevel = lvl; // RULE4 RULE19 RULE21 RULE2
            bestIdx = 5'(i);
            bestValid = 1'b1;
         end
      end
   end

   // Register writes; priorities and enables reset to zero.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         prioA <= REG_RESET; // RULE3
         prioB <= REG_RESET;
         convPrio <= REG_RESET;
      end else if (regWrite) begin
         if (hit(regAddr, PRIO_A_ADDR)) prioA <= regWdata;
         if (hit(regAddr, PRIO_B_ADDR)) prioB <= regWdata & PRIO_B_MASK; // RULE20
         if (hit(regAddr, CONV_PRIO_ADDR)) convPrio <= regWdata & CONV_PRIO_MASK;
      end
   end

   // Enable bits reset to blocked.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         timerEn <= REG_RESET; // RULE14
         ioEn <= REG_RESET;
         convEn <= REG_RESET;
      end else if (regWrite) begin
         if (hit(regAddr, TIMER_EN_ADDR)) timerEn <= regWdata & TIMER_MASK;
         if (hit(regAddr, IO_EN_ADDR)) ioEn <= regWdata;
         if (hit(regAddr, CONV_EN_ADDR)) convEn <= regWdata & CONV_EN_MASK;
      end
   end

   // Factor flags: events set, a written one clears, and a set in the same cycle wins.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ioFlag <= REG_RESET; // RULE18
         timerFlag <= REG_RESET;
         convFlag <= REG_RESET;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (srcEvent[i]) ioFlag[7-i] <= 1'b1;
            else if (regWrite && hit(regAddr, IO_FLAG_ADDR) && regWdata[7-i]) ioFlag[7-i] <= 1'b0;
         end
         for (int i = 0; i < 7; i++) begin
            if (srcEvent[8+i]) timerFlag[6-i] <= 1'b1;
            else if (regWrite && hit(regAddr, TIMER_FLAG_ADDR) && regWdata[6-i])
               timerFlag[6-i] <= 1'b0;
         end
         if (srcEvent[15]) convFlag[7] <= 1'b1;
         else if (regWrite && hit(regAddr, CONV_FLAG_ADDR) && regWdata[7]) convFlag[7] <= 1'b0;
      end
   end

   // The watchdog request is held until its exception entry takes it.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         nmiFlag <= 1'b0;
      end else if (nmiEvent) begin
         nmiFlag <= 1'b1;
      end else if (state == WAIT_INSN && instrDone && takenIdx == 5'(NMI_INDEX)) begin
         nmiFlag <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         regRdata <= 8'h00;
      end else if (regRead) begin
         case (regAddr)
            PRIO_A_ADDR: regRdata <= prioA;
            PRIO_B_ADDR: regRdata <= prioB;
            TIMER_EN_ADDR: regRdata <= timerEn;
            IO_EN_ADDR: regRdata <= ioEn;
            TIMER_FLAG_ADDR: regRdata <= timerFlag;
            IO_FLAG_ADDR: regRdata <= ioFlag;
            CONV_PRIO_ADDR: regRdata <= convPrio;
            CONV_EN_ADDR: regRdata <= convEn;
            CONV_FLAG_ADDR: regRdata <= convFlag;
            default: regRdata <= 8'h00; // RULE20
         endcase
      end else begin
         regRdata <= 8'h00;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         requestPending <= 1'b0;
      end else begin
         requestPending <= bestValid && state == IDLE;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         requestLevel <= 3'h0;
      end else begin
         requestLevel <= bestLevel;
      end
   end

   // Exception entry sequence.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state <= IDLE;
      end else begin
         case (state)
            IDLE: begin
               if (bestValid) state <= WAIT_INSN;
            end
            WAIT_INSN: begin
               if (instrDone) state <= maxMode ? PUSH_BANK : PUSH_PC_LO; // RULE10
            end
            PUSH_BANK: state <= PUSH_PC_LO;
            PUSH_PC_LO: state <= PUSH_PC_HI;
            PUSH_PC_HI: state <= PUSH_FLAGS;
            PUSH_FLAGS: state <= FETCH_LO;
            FETCH_LO: state <= FETCH_HI;
            FETCH_HI: state <= DONE;
            DONE: state <= IDLE;
            default: state <= IDLE;
         endcase
      end
   end

   // Context of the entry: the chosen source, then PC and flags at instruction end.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         takenIdx <= 5'h00;
         pcHold <= 16'h0000;
         flagsHold <= 8'h00;
      end else if (state == IDLE && bestValid) begin
         takenIdx <= bestIdx;
      end else if (state == WAIT_INSN && instrDone) begin
         pcHold <= pcIn; // RULE9
         flagsHold <= flagsIn;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         vecLow <= 8'h00;
      end else if (state == FETCH_LO) begin
         vecLow <= vectorData[7:0];
      end
   end

   // Stack side of the entry: one byte pushed per cycle.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         stackWrite <= 1'b0;
         stackData <= 8'h00;
      end else begin
         stackWrite <= 1'b0;
         case (state)
            PUSH_BANK: begin
               stackWrite <= 1'b1;
               stackData <= bankIn;
            end
            PUSH_PC_LO: begin
               stackWrite <= 1'b1;
               stackData <= pcHold[15:8];
            end
            PUSH_PC_HI: begin
               stackWrite <= 1'b1;
               stackData <= pcHold[7:0];
            end
            PUSH_FLAGS: begin
               stackWrite <= 1'b1;
               stackData <= flagsHold;
            end
            default: begin
            end
         endcase
      end
   end

   // Vector side: the low byte is read beside the flags push, the high byte next.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         vectorRead <= 1'b0;
         vectorAddr <= VEC_RESET;
      end else begin
         vectorRead <= 1'b0;
         case (state)
            PUSH_FLAGS: begin
               vectorRead <= 1'b1; // RULE11
               vectorAddr <= (takenIdx == 5'(NMI_INDEX)) ? VEC_NMI :
                  VEC_FIRST_SRC + VEC_STEP * 24'(takenIdx); // RULE12
            end
            FETCH_LO: begin
               vectorRead <= 1'b1;
               vectorAddr <= vectorAddr + 24'h000001;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pcLoad <= 1'b0;
         pcOut <= 16'h0000;
      end else begin
         pcLoad <= state == FETCH_HI;
         if (state == FETCH_HI) begin
            pcOut <= {vectorData[7:0], vecLow}; // RULE11
         end
      end
   end

   // Busy only after the interrupted instruction has ended, so the CPU can finish it.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         entryBusy <= 1'b0;
      end else begin
         entryBusy <= state != IDLE && state != WAIT_INSN; // RULE9
      end
   end

   // Mask: loaded on acceptance, restored from the stack on return.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cpuMask <= MASK_RESET;
      end else if (state == WAIT_INSN && instrDone) begin
         cpuMask <= (takenIdx == 5'(NMI_INDEX)) ? MASK_AFTER_NMI : // RULE7
            levelOf(systemOf(takenIdx), prioA, prioB, convPrio); // RULE6
      end else if (retire && !nest.empty) begin
         cpuMask <= nest.popData; // RULE8
      end
   end

   assign nest.push = state == WAIT_INSN && instrDone;
   assign nest.pushData = cpuMask;
   assign nest.pop = retire && !nest.empty && !(state == WAIT_INSN && instrDone);

   mask_stack u_stack (
      .mclk(mclk),
      .nrst(nrst),
      .nest(nest)
   );

   // Vectors 26h and 28h-FEh are never produced here: reserved and software traps.
   localparam logic [23:0] UNUSED_VEC_SPAN = VEC_SOFT_HI - VEC_SOFT_LO; // RULE13
endmodule : prioritized_interrupt_controller
`default_nettype wire

// ===== verif/cpu_model.sv
// CPU-side model: ends instructions at a fixed pace and serves vector bytes.
// Assumes registered entry outputs from the controller.
`timescale 1ns/1ps
`default_nettype none
module cpu_model #(
   parameter int INSN_CYCLES = 3
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic entryBusy,
   input wire logic vectorRead,
   input wire logic [23:0] vectorAddr,
   output logic instrDone,
   output logic [15:0] vectorData
);
   int cnt;
   // No instruction ends while exception entry runs.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt <= 0;
         instrDone <= 1'h0;
      end else begin
         cnt <= (cnt >= INSN_CYCLES - 1 || entryBusy) ? 0 : cnt + 1;
         instrDone <= !entryBusy && cnt == INSN_CYCLES - 1;
      end
   end
   // Memory byte is address xor 5A; the bus floats high outside a fetch.
   assign vectorData = vectorRead ? {8'h00, vectorAddr[7:0] ^ 8'h5A} : 16'hFFFF;
endmodule : cpu_model
`default_nettype wire

// ===== verif/intc_monitor.sv
// Checker on the interrupt controller top ports.
// Assumes one clock domain; bound to every controller instance.
`timescale 1ns/1ps
`default_nettype none
module intc_monitor
   import intc_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [23:0] regAddr,
   input wire logic regRead,
   input wire logic [7:0] regRdata,
   input wire logic instrDone,
   input wire logic retire,
   input wire logic [1:0] cpuMask,
   input wire logic requestPending,
   input wire logic [2:0] requestLevel,
   input wire logic [23:0] vectorAddr,
   input wire logic stackWrite,
   input wire logic vectorRead,
   input wire logic pcLoad
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   sequence s_fetch_lo;
      vectorRead && !$past(vectorRead);
   endsequence
   sequence s_fetch_hi;
      vectorRead && vectorAddr == $past(vectorAddr) + 24'h000001;
   endsequence
   AST_RD_IDLE: assert property (!regRead |=> regRdata == 8'h00)
      else $error("read data outside a read");
   AST_RD_UNMAP: assert property (regRead && regAddr == 24'h00FF26 |=> !regRdata)
      else $error("unmapped read not zero");
   AST_PRIOB_RSV: assert property (regRead && regAddr == PRIO_B_ADDR |=> !regRdata[7:4])
      else $error("priority b upper bits set");
   AST_CONV_RSV: assert property (regRead && regAddr == CONV_FLAG_ADDR |=> !regRdata[6:0])
      else $error("converter flag low bits set");
   AST_PEND_LVL: assert property ($rose(requestPending) |-> requestLevel > {1'h0, cpuMask})
      else $error("request not above mask");
   AST_PEND_NZ: assert property (requestPending |-> requestLevel != 3'h0)
      else $error("level zero request");
   AST_MASK_CAUSE: assert property ($changed(cpuMask) |-> $past(instrDone) || $past(retire))
      else $error("mask changed without cause");
   AST_NMI_MASK: assert property (vectorRead && vectorAddr == VEC_NMI |-> cpuMask == 2'h3)
      else $error("mask after watchdog entry");
   AST_VEC_RANGE: assert property (vectorRead |-> vectorAddr >= VEC_NMI && vectorAddr < VEC_RESERVED)
      else $error("vector out of range");
   AST_FETCH: assert property (s_fetch_lo |=> s_fetch_hi ##[1:2] pcLoad)
      else $error("vector fetch sequence");
   AST_FLAGS_PUSH: assert property (s_fetch_lo |-> stackWrite)
      else $error("no push beside first fetch");
endmodule : intc_monitor
bind prioritized_interrupt_controller intc_monitor mon_u (.mclk, .nrst, .regAddr, .regRead,
   .regRdata, .instrDone, .retire, .cpuMask, .requestPending, .requestLevel, .vectorAddr,
   .stackWrite, .vectorRead, .pcLoad);
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench for the interrupt controller.
// Assumes the CPU model paces instructions and serves vectors.
`timescale 1ns/1ps
`default_nettype none
module testbench
   import intc_pkg::*;
;
   logic mclk = '0, nrst = '0, regWrite = '0, regRead = '0, nmiEvent = '0;
   logic retire = '0, maxMode = '0, instrDone, requestPending, stackWrite;
   logic vectorRead, pcLoad, entryBusy;
   logic [23:0] regAddr = '0, vectorAddr;
   logic [7:0] regWdata = '0, regRdata, stackData;
   logic [15:0] srcEvent = '0, vectorData, pcOut;
   logic [1:0] cpuMask;
   logic [2:0] requestLevel;
   int n_errors = 0, num_checks = 0;
   int sh[16] = '{2, 2, 0, 6, 6, 4, 4, 4, 2, 2, 2, 0, 0, 0, 0, 6};
   logic [23:0] regs[10] = '{PRIO_A_ADDR, PRIO_B_ADDR, TIMER_EN_ADDR, IO_EN_ADDR,
      TIMER_FLAG_ADDR, IO_FLAG_ADDR, CONV_PRIO_ADDR, CONV_EN_ADDR, CONV_FLAG_ADDR, 24'h00FF26};
   logic [7:0] rmask[10] = '{8'hCF, 8'h0F, 8'h4F, 8'hCF, 8'h00, 8'h00, 8'hC0, 8'h80, 8'h00, 8'h00};
   prioritized_interrupt_controller dut_u (.mclk, .nrst, .regAddr, .regWdata, .regWrite,
      .regRead, .regRdata, .srcEvent, .nmiEvent, .instrDone, .retire, .maxMode,
      .pcIn(16'hC3A5), .flagsIn(8'h96), .bankIn(8'h4B), .vectorData, .cpuMask,
      .requestPending, .requestLevel, .vectorAddr, .stackWrite, .stackData, .vectorRead,
      .pcLoad, .pcOut, .entryBusy);
   cpu_model #(.INSN_CYCLES(3)) cpu_u (.mclk, .nrst, .entryBusy, .vectorRead, .vectorAddr,
      .instrDone, .vectorData);
   initial forever #12.5 mclk = ~mclk;
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_sim
   task automatic wr(logic [23:0] a, logic [7:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'h1;
      @(posedge mclk);
      regWrite <= 1'h0;
   endtask : wr
   task automatic rc(logic [23:0] a, logic [7:0] e);
      @(posedge mclk);
      regAddr <= a;
      regRead <= 1'h1;
      @(posedge mclk);
      regRead <= 1'h0;
      @(negedge mclk);
      chk(regRdata, e);
   endtask : rc
   task automatic ev(logic [15:0] m, logic nmi);
      @(posedge mclk);
      srcEvent <= m;
      nmiEvent <= nmi;
      @(posedge mclk);
      srcEvent <= '0;
      nmiEvent <= 1'h0;
   endtask : ev
   task automatic ret();
      @(posedge mclk);
      retire <= 1'h1;
      @(posedge mclk);
      retire <= 1'h0;
   endtask : ret
   task automatic quiet();
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      chk(requestPending, 1'h0);
   endtask : quiet
   // Follows one exception entry and judges pushes, vector and mask.
   task automatic entry(logic [23:0] vec, logic [1:0] m);
      logic [7:0] st[4];
      logic [23:0] va;
      logic [2:0] lvSeen;
      int n;
      n = 0;
      va = '1;
      lvSeen = '0;
      for (int k = 0; k < 80; k++) begin
         @(negedge mclk);
         if (stackWrite && n < 4) begin
            st[n] = stackData;
            n++;
         end
         if (vectorRead && va === '1) va = vectorAddr;
         if (requestPending) lvSeen = requestLevel;
         if (pcLoad) begin
            chk(lvSeen, vec == VEC_NMI ? NMI_LEVEL : {1'b0, m});
            chk(entryBusy, 1'h1);
            chk(va, vec);
            chk(pcOut, {vec[7:0] ^ 8'h5B, vec[7:0] ^ 8'h5A});
            chk(cpuMask, m);
            chk(n, maxMode ? 4 : 3);
            chk({st[0], st[n-3], st[n-2], st[n-1]}, {maxMode ? 8'h4B : 8'hC3, 24'hC3A596});
            return;
         end
      end
      n_errors++;
      $display("Error %0t: no entry", $time);
      end_sim();
   endtask : entry
   task automatic t_regs();
      foreach (regs[i]) rc(regs[i], 8'h00);
      foreach (regs[i]) begin
         wr(regs[i], 8'hCF);
         rc(regs[i], rmask[i]);
         wr(regs[i], 8'h00);
      end
      $display("register test done");
   endtask : t_regs
   task automatic t_flags();
      ev(16'hFFFF, 1'h0);
      rc(TIMER_FLAG_ADDR, 8'h7F);
      rc(CONV_FLAG_ADDR, 8'h80);
      wr(IO_FLAG_ADDR, 8'h00);
      rc(IO_FLAG_ADDR, 8'hFF);
      wr(IO_FLAG_ADDR, 8'hA5);
      rc(IO_FLAG_ADDR, 8'h5A);
      foreach (regs[i]) wr(regs[i], rmask[i] == 8'h00 ? 8'hFF : 8'h00);
      $display("flag test done");
   endtask : t_flags
   task automatic t_src();
      logic [23:0] ea, pa;
      logic [7:0] b;
      logic [1:0] lv;
      for (int i = 0; i < 16; i++) begin
         lv = 2'(i % 3 + 1);
         b = i < 8 ? 8'h01 << (7 - i) : i < 15 ? 8'h01 << (14 - i) : 8'h80;
         ea = i < 8 ? IO_EN_ADDR : i < 15 ? TIMER_EN_ADDR : CONV_EN_ADDR;
         pa = i < 3 ? PRIO_B_ADDR : i == 15 ? CONV_PRIO_ADDR : PRIO_A_ADDR;
         maxMode <= i[0];
         wr(ea, b);
         ev(16'(1 << i), 1'h0);
         quiet();
         wr(pa, 8'(lv) << sh[i]);
         entry(VEC_FIRST_SRC + 24'(2 * i), lv);
         rc(ea + 24'h000002, b);
         wr(ea + 24'h000002, b);
         ret();
         @(negedge mclk);
         chk(cpuMask, 2'h0);
         wr(ea, 8'h00);
         wr(pa, 8'h00);
      end
      $display("source test done");
   endtask : t_src
   task automatic t_nest();
      wr(PRIO_A_ADDR, 8'h0A);
      wr(CONV_PRIO_ADDR, 8'hC0);
      wr(TIMER_EN_ADDR, 8'h11);
      wr(CONV_EN_ADDR, 8'h80);
      ev(16'hC400, 1'h0);
      entry(VEC_LAST_SRC, 2'h3);
      wr(CONV_FLAG_ADDR, 8'h80);
      ret();
      entry(24'h00001A, 2'h2);
      ev(16'h0000, 1'h1);
      entry(VEC_NMI, MASK_AFTER_NMI);
      ev(16'h8000, 1'h0);
      quiet();
      wr(TIMER_FLAG_ADDR, 8'h10);
      wr(CONV_FLAG_ADDR, 8'h80);
      ret();
      @(negedge mclk);
      chk(cpuMask, 2'h2);
      ret();
      entry(24'h000022, 2'h2);
      wr(TIMER_FLAG_ADDR, 8'h01);
      ret();
      @(negedge mclk);
      chk(cpuMask, 2'h0);
      $display("nesting test done");
   endtask : t_nest
   initial begin
      repeat (4) @(posedge mclk);
      nrst <= 1'h1;
      t_regs();
      t_flags();
      t_src();
      t_nest();
      end_sim();
   end
endmodule : testbench
`default_nettype wire
